// *** rtl/datalog_pkg.sv ***
// Purpose: Shared constants and types for the gas data-logging sequencer.
// Assumes: One 40 MHz clock, synchronous active-high reset, Avalon-MM register slave.
// Notes:   All offsets are byte addresses of 32-bit words.
//
// Notes on behaviour
// - Logging interval is 1 s to 60 min in 1 s steps; one set per interval.
// - Each sensor stores average or peak per interval, per measurement type.
// - Time stamp, user, site, calibration date, alarm limits are stored too; the serial is XORed into the upper half of the ident record.
// - Every record goes to nonvolatile log memory for later readout.
// - Automatic mode logs from power-on to power-off without keys.
// - Manual mode: confirm key on start prompt starts, on stop prompt stops.
// - Manual mode has a maximum-duration timer ending the session.
// - Periodic mode starts and stops daily at preset hour and minute.
// - Scheduled mode starts and stops once at preset month, date, hour, minute.
// - Each start opens a new event with header before measurement records.
// - After 900 intervals in an event, a new event with header is opened.
// - Programming mode suspends logging; leaving it resumes automatically.
// - Comm standby suspends; resume on exit only in automatic mode.
// - Resuming after suspension always opens a new event.
// - Full log memory raises a memory-full alarm.
package datalog_pkg;

    // -------------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------------
    localparam logic [5:0] OFS_CTRL      = 6'h00;
    localparam logic [5:0] OFS_INTERVAL  = 6'h04;
    localparam logic [5:0] OFS_MAXDUR    = 6'h08;
    localparam logic [5:0] OFS_START_TM  = 6'h0c;
    localparam logic [5:0] OFS_STOP_TM   = 6'h10;
    localparam logic [5:0] OFS_IDENT     = 6'h14;
    localparam logic [5:0] OFS_CALDATE   = 6'h18;
    localparam logic [5:0] OFS_LIMITS    = 6'h1c;
    localparam logic [5:0] OFS_STATUS    = 6'h20;
    localparam logic [5:0] OFS_IRQ_STAT  = 6'h24;
    localparam logic [5:0] OFS_IRQ_MASK  = 6'h28;
    localparam logic [5:0] OFS_COUNTS    = 6'h2c;

    // CTRL fields
    localparam int CTRL_MODE_LSB = 0;   // 2 bits
    localparam int CTRL_PEAK_BIT = 2;   // 1 = peak, 0 = average
    localparam int CTRL_SER_LSB  = 8;   // 16-bit serial number

    // Reset values and limits
    localparam logic [11:0] INTERVAL_RST = 12'h03c;  // 60 s
    localparam logic [15:0] MAXDUR_RST   = 16'h0000; // 0 = no limit
    localparam logic [11:0] INTERVAL_MAX = 12'he10;  // 3600 s
    localparam logic [9:0]  EVENT_LEN    = 10'h384;  // 900 intervals

    // Interrupt bits
    localparam int IRQ_W        = 4;
    localparam int IRQ_START    = 0;
    localparam int IRQ_STOP     = 1;
    localparam int IRQ_EVENT    = 2;
    localparam int IRQ_MEMFULL  = 3;

    // Record kinds on the memory port
    localparam logic [2:0] REC_HDR_TIME  = 3'h0;
    localparam logic [2:0] REC_HDR_PER   = 3'h1;
    localparam logic [2:0] REC_HDR_LIM   = 3'h2;
    localparam logic [2:0] REC_HDR_ID    = 3'h3;
    localparam logic [2:0] REC_HDR_CAL   = 3'h4;
    localparam logic [2:0] REC_SAMPLE    = 3'h5;

    typedef enum logic [1:0] {
        MODE_AUTO, MODE_MANUAL, MODE_PERIODIC, MODE_SCHED
    } log_mode_t;

    // Real-time clock, BCD-free binary
    typedef struct packed {
        logic [3:0] month;
        logic [4:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } rtc_t;

    // Record going to nonvolatile memory
    typedef struct packed {
        logic [2:0]  kind;
        logic [2:0]  sensor;
        logic [31:0] data;
    } rec_t;

    // Key and mode-controller inputs
    typedef struct packed {
        logic power_on;
        logic confirm;
        logic prompt_start;
        logic prompt_stop;
        logic prog_mode;
        logic comm_standby;
    } ui_t;

endpackage

// *** rtl/gas_datalog_sequencer.sv ***
// Purpose: Sequences data logging: start/stop modes, events, headers, samples.
// Assumes: Inputs synchronous to sys_clk_in; tick_1s_in is a one-cycle pulse.
// Notes:   One record write at a time; mem_ready_in stalls the sequencer.
module gas_datalog_sequencer
    import datalog_pkg::*;
#(
    parameter int NSENS = 5
) (
    // Clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              sys_rst_in,
    // Avalon-MM slave
    input  wire logic [5:0]        avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [31:0]       avs_writedata_in,
    output logic      [31:0]       avs_readdata_out,
    output logic                   avs_waitrequest_out,
    // Instrument side
    input  wire logic              tick_1s_in,
    input  wire rtc_t              rtc_in,
    input  wire ui_t               ui_in,
    input  wire logic [NSENS*16-1:0] reading_in,
    // Log memory side
    output rec_t                   rec_out,
    output logic                   rec_valid_out,
    input  wire logic              mem_ready_in,
    input  wire logic              mem_full_in,
    // Indications
    output logic                   logging_out,
    output logic                   mem_full_alarm_out,
    output logic                   irq_out
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_HDR, ST_RUN, ST_SAMPLE, ST_SUSP
    } st_t;

    typedef struct packed {
        st_t                  st;
        logic [1:0]           mode;
        logic                 peak;
        logic [15:0]          serial;
        logic [11:0]          interval;
        logic [15:0]          maxdur;
        logic [19:0]          start_tm;
        logic [19:0]          stop_tm;
        logic [31:0]          ident;
        logic [31:0]          caldate;
        logic [31:0]          limits;
        logic [IRQ_W-1:0]     irq_stat;
        logic [IRQ_W-1:0]     irq_mask;
        logic [11:0]          ivl_cnt;
        logic [9:0]           ev_cnt;
        logic [15:0]          dur_cnt;
        logic [2:0]           idx;
        logic [NSENS*24-1:0]  acc;
        logic [NSENS*16-1:0]  pk;
        logic [11:0]          nsamp;
        logic                 resume_auto;
        logic                 prog_d;
        logic                 comm_d;
        logic                 sched_done;
        logic                 rd_ack;
        logic [31:0]          rdata;
    } state_t;

    state_t s_reg, s_next;

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    // Hour and minute (20-bit packed: month,day,hour,minute) match against the clock
    function automatic logic hm_match(input logic [19:0] t, input rtc_t r);
        hm_match = (t[10:6] == r.hour) && (t[5:0] == r.minute) && (r.second == 6'h00);
    endfunction

    function automatic logic full_match(input logic [19:0] t, input rtc_t r);
        full_match = hm_match(t, r) && (t[19:16] == r.month) && (t[15:11] == r.day);
    endfunction

    // Map 0 and values above 3600 s to 3600 s, keep 1 .. 3600 s
    function automatic logic [11:0] clamp_ivl(input logic [31:0] v);
        if (v[11:0] == 12'h000 || v > {20'h00000, INTERVAL_MAX}) clamp_ivl = INTERVAL_MAX;
        else clamp_ivl = v[11:0];
    endfunction

    logic access;
    logic suspend;
    logic start_cond;
    logic stop_cond;
    logic [IRQ_W-1:0] ev;
    logic [31:0] avg_val;

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always_comb begin
        s_next     = s_reg;
        ev         = '0;
        s_next.rd_ack = 1'b0;
        access     = (avs_read_in || avs_write_in) && !s_reg.rd_ack;
        suspend    = ui_in.prog_mode || ui_in.comm_standby;
        s_next.prog_d = ui_in.prog_mode;
        s_next.comm_d = ui_in.comm_standby;

        // Start and stop conditions per mode
        start_cond = 1'b0;
        stop_cond  = 1'b0;
        case (log_mode_t'(s_reg.mode))
            MODE_AUTO: begin
                start_cond = ui_in.power_on;
                stop_cond  = !ui_in.power_on;
            end
            MODE_MANUAL: begin
                start_cond = ui_in.confirm && ui_in.prompt_start;
                stop_cond  = ui_in.confirm && ui_in.prompt_stop;
                if (s_reg.maxdur != 16'h0000 && s_reg.dur_cnt >= s_reg.maxdur)
                    stop_cond = 1'b1;
            end
            MODE_PERIODIC: begin
                start_cond = hm_match(s_reg.start_tm, rtc_in);
                stop_cond  = hm_match(s_reg.stop_tm, rtc_in);
            end
            MODE_SCHED: begin
                start_cond = !s_reg.sched_done && full_match(s_reg.start_tm, rtc_in);
                stop_cond  = full_match(s_reg.stop_tm, rtc_in);
            end
            default: ;
        endcase

        // Accumulate per-sensor average sum and peak every second
        if (tick_1s_in && (s_reg.st == ST_RUN)) begin
            for (int i = 0; i < NSENS; i++) begin
                s_next.acc[i*24 +: 24] = s_reg.acc[i*24 +: 24] + {8'h00, reading_in[i*16 +: 16]};
                if (reading_in[i*16 +: 16] > s_reg.pk[i*16 +: 16])
                    s_next.pk[i*16 +: 16] = reading_in[i*16 +: 16];
            end
            s_next.nsamp = s_reg.nsamp + 12'h001;
            if (s_reg.mode == MODE_MANUAL) s_next.dur_cnt = s_reg.dur_cnt + 16'h0001;
        end

        // Sequencer
        case (s_reg.st)
            ST_IDLE: begin
                if (suspend) begin
                    s_next.st = ST_IDLE;
                end else if (s_reg.resume_auto && !s_reg.comm_d && !s_reg.prog_d) begin
                    s_next.resume_auto = 1'b0;
                end else if (start_cond && !mem_full_in) begin
                    s_next.st = ST_HDR;
                    s_next.idx = 3'h0;
                    s_next.dur_cnt = 16'h0000;
                    if (s_reg.mode == MODE_SCHED) s_next.sched_done = 1'b1;
                    ev[IRQ_START] = 1'b1;
                end
            end
            ST_HDR: begin
                if (mem_ready_in) begin
                    if (s_reg.idx == REC_HDR_CAL) begin
                        s_next.st = ST_RUN;
                        s_next.ev_cnt = 10'h000;
                        s_next.ivl_cnt = s_reg.interval;
                        s_next.acc = '0;
                        s_next.pk = '0;
                        s_next.nsamp = 12'h000;
                        ev[IRQ_EVENT] = 1'b1;
                    end else begin
                        s_next.idx = s_reg.idx + 3'h1;
                    end
                end
            end
            ST_RUN: begin
                if (suspend) begin
                    s_next.st = ST_SUSP;
                    ev[IRQ_STOP] = 1'b1;
                end else if (stop_cond) begin
                    s_next.st = ST_IDLE;
                    ev[IRQ_STOP] = 1'b1;
                end else if (tick_1s_in) begin
                    if (s_reg.ivl_cnt <= 12'h001) begin
                        s_next.st = ST_SAMPLE;
                        s_next.idx = 3'h0;
                    end else begin
                        s_next.ivl_cnt = s_reg.ivl_cnt - 12'h001;
                    end
                end
            end
            ST_SAMPLE: begin
                if (mem_full_in) begin
                    s_next.st = ST_IDLE;
                    ev[IRQ_MEMFULL] = 1'b1;
                    ev[IRQ_STOP] = 1'b1;
                end else if (mem_ready_in) begin
                    if (s_reg.idx == 3'(NSENS - 1)) begin
                        s_next.ivl_cnt = s_reg.interval;
                        s_next.acc = '0;
                        s_next.pk = '0;
                        s_next.nsamp = 12'h000;
                        if (s_reg.ev_cnt == EVENT_LEN - 10'h001) begin
                            s_next.st = ST_HDR;
                            s_next.idx = 3'h0;
                        end else begin
                            s_next.st = ST_RUN;
                            s_next.ev_cnt = s_reg.ev_cnt + 10'h001;
                        end
                    end else begin
                        s_next.idx = s_reg.idx + 3'h1;
                    end
                end
            end
            ST_SUSP: begin
                if (!ui_in.prog_mode && !ui_in.comm_standby) begin
                    if (s_reg.comm_d && s_reg.mode != MODE_AUTO) begin
                        s_next.st = ST_IDLE;
                        s_next.resume_auto = 1'b1;
                    end else begin
                        s_next.st = ST_HDR;
                        s_next.idx = 3'h0;
                        ev[IRQ_START] = 1'b1;
                    end
                end else if (ui_in.comm_standby) begin
                    s_next.comm_d = 1'b1;                                      // Remember standby cause
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
        // Standby memory only cleared once suspension ends
        if (s_reg.st == ST_SUSP && !ui_in.comm_standby && ui_in.prog_mode) s_next.comm_d = s_reg.comm_d;
        if (mem_full_in && !s_reg.irq_stat[IRQ_MEMFULL]) ev[IRQ_MEMFULL] = 1'b1;

        // Register access, one wait cycle then acknowledge
        if (access) begin
            s_next.rd_ack = 1'b1;
            case (avs_address_in)
                OFS_CTRL:     s_next.rdata = {8'h00, s_reg.serial, 5'h00, s_reg.peak, s_reg.mode};
                OFS_INTERVAL: s_next.rdata = {20'h00000, s_reg.interval};
                OFS_MAXDUR:   s_next.rdata = {16'h0000, s_reg.maxdur};
                OFS_START_TM: s_next.rdata = {12'h000, s_reg.start_tm};
                OFS_STOP_TM:  s_next.rdata = {12'h000, s_reg.stop_tm};
                OFS_IDENT:    s_next.rdata = s_reg.ident;
                OFS_CALDATE:  s_next.rdata = s_reg.caldate;
                OFS_LIMITS:   s_next.rdata = s_reg.limits;
                OFS_STATUS:   s_next.rdata = {26'h0, mem_full_in, s_reg.st != ST_IDLE && s_reg.st != ST_SUSP,
                                              1'b0, s_reg.st};
                OFS_IRQ_STAT: s_next.rdata = {28'h0, s_reg.irq_stat};
                OFS_IRQ_MASK: s_next.rdata = {28'h0, s_reg.irq_mask};
                OFS_COUNTS:   s_next.rdata = {s_reg.dur_cnt, 6'h00, s_reg.ev_cnt};
                default:      s_next.rdata = 32'h0;                 // Unmapped reads zero
            endcase
            if (avs_write_in) begin
                case (avs_address_in)
                    OFS_CTRL: begin
                        s_next.mode   = avs_writedata_in[CTRL_MODE_LSB +: 2];
                        s_next.peak   = avs_writedata_in[CTRL_PEAK_BIT];
                        s_next.serial = avs_writedata_in[CTRL_SER_LSB +: 16];
                        s_next.sched_done = 1'b0;
                    end
                    OFS_INTERVAL: s_next.interval = clamp_ivl(avs_writedata_in);
                    OFS_MAXDUR:   s_next.maxdur   = avs_writedata_in[15:0];
                    OFS_START_TM: s_next.start_tm = avs_writedata_in[19:0];
                    OFS_STOP_TM:  s_next.stop_tm  = avs_writedata_in[19:0];
                    OFS_IDENT:    s_next.ident    = avs_writedata_in;
                    OFS_CALDATE:  s_next.caldate  = avs_writedata_in;
                    OFS_LIMITS:   s_next.limits   = avs_writedata_in;
                    OFS_IRQ_STAT: s_next.irq_stat = s_reg.irq_stat & ~avs_writedata_in[IRQ_W-1:0];
                    OFS_IRQ_MASK: s_next.irq_mask = avs_writedata_in[IRQ_W-1:0];
                    default: ;
                endcase
            end
        end
        // Hardware set wins over a write-one clear in the same cycle
        s_next.irq_stat = s_next.irq_stat | ev;
    end

    // -------------------------------------------------------------------------
    // Record output, driven from state and rtc_in, so data is stable while stalled unless rtc_in changes
    // -------------------------------------------------------------------------
    always_comb begin
        rec_out       = '0;
        rec_valid_out = 1'b0;
        avg_val       = 32'h0;
        if (s_reg.st == ST_HDR) begin
            rec_valid_out = 1'b1;
            rec_out.kind  = s_reg.idx;
            case (s_reg.idx)
                REC_HDR_TIME: rec_out.data = {12'h000, rtc_in[25:6]};
                REC_HDR_PER:  rec_out.data = {12'h000, s_reg.peak, 3'h0, s_reg.interval, 2'h0, s_reg.mode};
                REC_HDR_LIM:  rec_out.data = s_reg.limits;
                REC_HDR_ID:   rec_out.data = s_reg.ident ^ {s_reg.serial, 16'h0000};
                default:      rec_out.data = s_reg.caldate;
            endcase
        end else if (s_reg.st == ST_SAMPLE) begin
            rec_valid_out  = !mem_full_in;
            rec_out.kind   = REC_SAMPLE;
            rec_out.sensor = s_reg.idx;
            for (int i = 0; i < NSENS; i++) begin
                if (3'(i) == s_reg.idx)
                    avg_val = {8'h00, s_reg.acc[i*24 +: 24]} / {20'h00000, s_reg.nsamp | {11'h000, ~|s_reg.nsamp}};
            end
            rec_out.data = s_reg.peak ? {16'h0000, s_reg.pk[s_reg.idx*16 +: 16]} : avg_val;
            rec_out.data[31:26] = rtc_in.minute;
        end
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            s_reg          <= '0;
            s_reg.st       <= ST_IDLE;
            s_reg.interval <= INTERVAL_RST;
            s_reg.maxdur   <= MAXDUR_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs
    assign avs_readdata_out    = s_reg.rdata;
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !s_reg.rd_ack;
    assign logging_out         = (s_reg.st == ST_RUN) || (s_reg.st == ST_SAMPLE) || (s_reg.st == ST_HDR);
    assign mem_full_alarm_out  = s_reg.irq_stat[IRQ_MEMFULL];
    assign irq_out             = |(s_reg.irq_stat & s_reg.irq_mask);

endmodule

// *** verification/log_mem.sv ***
// Purpose: Log memory model that keeps every accepted record.
// Assumes: Ready changes only just after a rising edge.
// Notes:   slow_in stalls every other cycle so held records get exercised.
module log_mem
    import datalog_pkg::*;
(
    // Clock and stall control
    input  wire logic clk_in,
    input  wire logic slow_in,
    // Record stream
    input  wire rec_t rec_in,
    input  wire logic valid_in,
    output logic      ready_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic phase_reg = 1'b0;
    rec_t log_q[$];
    // Store on each accepted transfer, the way the flash would
    always @(posedge clk_in) begin
        if (valid_in && ready_out)
            log_q.push_back(rec_in);
        phase_reg <= !phase_reg;
        ready_out <= !slow_in || phase_reg;
    end
    initial ready_out = 1'b0;
endmodule

// *** verification/gas_datalog_sequencer_props.sv ***
// Purpose: Port-level checks for the data-logging sequencer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every instance of the sequencer.
module gas_datalog_sequencer_props
    import datalog_pkg::*;
#(
    parameter int NSENS = 5
) (
    // Clock, reset and bus handshake
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    // Instrument and memory side
    input wire rtc_t rtc_in,
    input wire ui_t  ui_in,
    input wire rec_t rec_out,
    input wire logic rec_valid_out,
    input wire logic mem_ready_in,
    input wire logic mem_full_in,
    // Indications
    input wire logic logging_out,
    input wire logic mem_full_alarm_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Handshake and record stream
    bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("waitrequest not low one cycle after request");
    rec_hold_a: assert property (rec_valid_out && !mem_ready_in && !mem_full_in |=> rec_valid_out && $stable(rec_out))
        else $error("record changed before acceptance");
    hdr_order_a: assert property (rec_valid_out && mem_ready_in && rec_out.kind < REC_HDR_CAL
        |=> rec_valid_out && rec_out.kind == $past(rec_out.kind) + 3'h1) else $error("header out of order");
    sens_order_a: assert property (rec_valid_out && mem_ready_in && rec_out.kind == REC_SAMPLE &&
        rec_out.sensor < NSENS - 1 |=> mem_full_in || (rec_valid_out && rec_out.sensor == $past(rec_out.sensor) + 3'h1))
        else $error("sensor samples out of order");
    stamp_minute_a: assert property (rec_valid_out && rec_out.kind == REC_SAMPLE |->
        rec_out.data[31:26] == rtc_in.minute) else $error("sample time stamp wrong");
    // Suspension and alarm
    prog_stop_a: assert property ($rose(ui_in.prog_mode) |-> ##[1:4] !logging_out)
        else $error("logging kept on in programming mode");
    standby_stop_a: assert property ($rose(ui_in.comm_standby) |-> ##[1:4] !logging_out)
        else $error("logging kept on in standby");
    full_alarm_a: assert property (mem_full_in && logging_out |-> ##[1:30] mem_full_alarm_out)
        else $error("memory full alarm missing");
    cover property (rec_valid_out && mem_ready_in && rec_out.kind == REC_HDR_CAL);
    cover property ($fell(logging_out));
    cover property ($rose(mem_full_alarm_out));
endmodule
bind gas_datalog_sequencer gas_datalog_sequencer_props #(.NSENS(NSENS)) u_props (.*);

// *** verification/gas_datalog_sequencer_bench.sv ***
// Purpose: Self-checking bench for the data-logging sequencer.
// Assumes: 40 MHz clock; registers reached over Avalon-MM.
// Notes:   Mask polarity is checked by contrast, not by value.
module gas_datalog_sequencer_bench import datalog_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NS = 5;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, tick = 1'b0, slow = 1'b1, full = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic wreq, vld, rdy, logg, alarm, irq, i0;
    ui_t ui = '0;
    rtc_t rtc = {4'h3, 5'h05, 5'h07, 6'h09, 6'h01};
    logic [NS*16-1:0] rdg = {16'h0050, 16'h0040, 16'h0030, 16'h0020, 16'h0010};
    rec_t rec, r;
    int fail_count = 0, tests_run = 0, h;
    gas_datalog_sequencer #(.NSENS(NS)) u_gas_datalog_sequencer (.sys_clk_in(clk), .sys_rst_in(rst),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .tick_1s_in(tick), .rtc_in(rtc), .ui_in(ui), .reading_in(rdg), .rec_out(rec),
        .rec_valid_out(vld), .mem_ready_in(rdy), .mem_full_in(full), .logging_out(logg),
        .mem_full_alarm_out(alarm), .irq_out(irq));
    log_mem u_log_mem (.clk_in(clk), .slow_in(slow), .rec_in(rec), .valid_in(vld), .ready_out(rdy));
    initial forever #12.5 clk = ~clk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Bus access: request held until waitrequest is seen low
    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= d;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic tk(input int n);
        repeat (n) begin
            @(posedge clk) tick <= 1'b1;
            @(posedge clk) tick <= 1'b0;
            wt(20);
        end
    endtask
    // Confirm key with the start or the stop prompt shown
    task automatic press(input logic st);
        @(posedge clk);
        ui.prompt_start <= st;
        ui.prompt_stop <= !st;
        ui.confirm <= 1'b1;
        @(posedge clk) ui.confirm <= 1'b0;
        wt(20);
    endtask
    function automatic int hdrs();
        hdrs = 0;
        foreach (u_log_mem.log_q[i]) hdrs += int'(u_log_mem.log_q[i].kind == REC_HDR_TIME);
    endfunction
    task automatic report_and_stop();
        if (fail_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        wt(60000);
        fail_count++;
        report_and_stop();
    end
    initial begin
        wt(6);
        rst <= 1'b0;
        acc(1'b0, OFS_INTERVAL, 32'h0);
        chk("interval_rst", 32'h3c, q);
        acc(1'b0, OFS_MAXDUR, 32'h0);
        chk("maxdur_rst", 32'h0, q);
        acc(1'b0, 6'h30, 32'h0);
        chk("unmapped", 32'h0, q);
        acc(1'b1, OFS_INTERVAL, 32'h2);
        acc(1'b1, OFS_CTRL, 32'h1204);
        @(posedge clk) ui.power_on <= 1'b1;
        wt(40);
        chk("auto_start", 32'h1, logg);
        chk("hdr_count", 32'h5, u_log_mem.log_q.size());
        for (int k = 0; k < 5; k++) chk("hdr_kind", k, u_log_mem.log_q[k].kind);
        tk(1);
        chk("early_count", 32'h5, u_log_mem.log_q.size());
        tk(1);
        chk("set_count", 32'ha, u_log_mem.log_q.size());
        for (int k = 0; k < NS; k++) begin
            r = u_log_mem.log_q[5+k];
            chk("sensor", k, r.sensor);
            chk("sample", rdg[k*16+:16], r.data[15:0]);
            chk("stamp", rtc.minute, r.data[31:26]);
        end
        acc(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("irq_start", 32'h1, q[IRQ_START]);
        acc(1'b1, OFS_IRQ_MASK, 32'h0);
        i0 = irq;
        acc(1'b1, OFS_IRQ_MASK, 32'hf);
        chk("irq_mask", 32'h1, i0 ^ irq);
        acc(1'b1, OFS_IRQ_STAT, 32'hf);
        chk("irq_clear", 32'h0, irq);
        // Programming mode, then standby, each resuming in automatic mode
        for (int s = 0; s < 2; s++) begin
            h = hdrs();
            @(posedge clk) {ui.prog_mode, ui.comm_standby} <= s ? 2'b01 : 2'b10;
            wt(20);
            chk("paused", 32'h0, logg);
            @(posedge clk) {ui.prog_mode, ui.comm_standby} <= 2'b00;
            wt(40);
            chk("resumed", 32'h1, logg);
            chk("new_event", h + 1, hdrs());
        end
        acc(1'b1, OFS_INTERVAL, 32'h1);
        slow <= 1'b0;
        h = hdrs();
        tk(900);
        chk("event_open", h, hdrs());
        tk(1);
        chk("event_next", h + 1, hdrs());
        slow <= 1'b1;
        acc(1'b1, OFS_CTRL, 32'h1);
        @(posedge clk) ui.comm_standby <= 1'b1;
        wt(5);
        @(posedge clk) ui.comm_standby <= 1'b0;
        wt(20);
        chk("manual_standby", 32'h0, logg);
        press(1'b1);
        chk("manual_start", 32'h1, logg);
        press(1'b0);
        chk("manual_stop", 32'h0, logg);
        acc(1'b1, OFS_INTERVAL, 32'h2);
        acc(1'b1, OFS_MAXDUR, 32'h3);
        press(1'b1);
        tk(1);
        rdg[15:0] <= 16'h0030;
        tk(1);
        chk("dur_running", 32'h1, logg);
        chk("average", 32'h20, u_log_mem.log_q[$-4].data[15:0]);
        tk(2);
        chk("dur_expired", 32'h0, logg);
        // Periodic then scheduled, matched on the whole minute
        for (int m = 2; m < 4; m++) begin
            acc(1'b1, OFS_START_TM, {12'h0, rtc.month, rtc.day, rtc.hour, 6'h0a});
            acc(1'b1, OFS_STOP_TM, {12'h0, rtc.month, rtc.day, rtc.hour, 6'h0b});
            acc(1'b1, OFS_CTRL, m);
            @(posedge clk) rtc.minute <= 6'h0a;
            rtc.second <= 6'h00;
            wt(20);
            chk("timed_start", 32'h1, logg);
            @(posedge clk) rtc.minute <= 6'h0b;
            wt(20);
            chk("timed_stop", 32'h0, logg);
        end
        @(posedge clk) rtc.minute <= 6'h0a;
        wt(20);
        chk("sched_once", 32'h0, logg);
        acc(1'b1, OFS_CTRL, 32'h0);
        @(posedge clk) ui.power_on <= 1'b0;
        wt(20);
        chk("power_off", 32'h0, logg);
        @(posedge clk) ui.power_on <= 1'b1;
        wt(40);
        @(posedge clk) full <= 1'b1;
        tk(2);
        chk("mem_alarm", 32'h1, alarm);
        chk("full_stop", 32'h0, logg);
        report_and_stop();
    end
endmodule
